// ---- design/anfa_seq.sv ----
// Overview of operation
// RULE1: six active-low chip selects, index 0 to 5, each framing an access.
// RULE2: two wait inputs, either one selectable per access.
// RULE3: single read samples data after first-sample delay cycles from start.
// RULE4: first-sample delay field times the capture of the first word.
// RULE5: page read captures first word after the first-sample delay.
// RULE6: each later page word captured after page-word interval cycles.
// RULE7: later page address phases last exactly the page-word interval.
// RULE8: page interval comes from its own field, apart from the first delay.
// RULE9: page read fetches four 16-bit words, new address for each.
// RULE10: 32-bit read from 16-bit flash as two words, plus single reads.
// RULE11: functional clock stays internal; no clock pin is driven.
// RULE12: muxed write drives low address on shared lines, then write data.
// RULE13: address-valid strobe low only while low address sits on the bus; non-muxed reads also pull it low for one cycle with ad_oe low.
// RULE14: flash holds read data valid up to the sampling edge.
`timescale 1ns/10ps
`default_nettype none
`include "anfa_cfg.svh"
module anfa_seq
  import anfa_pkg::*;
#(
  parameter logic [`ANFA_CW-1:0] ADV_CYC = `ANFA_ADV_CYC,
  parameter logic [`ANFA_CW-1:0] WR_CYC = `ANFA_WR_CYC,
  parameter logic [`ANFA_CW-1:0] IDLE_CYC = `ANFA_IDLE_CYC
) (
  input wire logic core_clk, // functional clock
  input wire logic rstn, // async reset, active low
  input wire logic req_valid, // access request
  input wire anfa_req_t req, // access description
  output logic req_ready, // idle, request taken
  input wire logic [`ANFA_NWAIT-1:0] wait_in, // memory wait inputs
  input wire logic [`ANFA_DW-1:0] ad_in, // data/address lines in
  output anfa_pins_t pins, // memory pins
  output logic rd_valid, // read word captured
  output logic [31:0] rd_data, // captured read data
  output logic rd_last, // final word of access
  output logic done // access finished
);
  anfa_state_t st_q, st_d;
  anfa_req_t r_q, r_d;
  logic [`ANFA_CW-1:0] cnt_q, cnt_d;
  logic [1:0] word_q, word_d;
  anfa_pins_t pins_d;
  logic rd_valid_d, rd_last_d, done_d, req_ready_d;
  logic [31:0] rd_data_d;

  function automatic logic [`ANFA_NCS-1:0] cs_decode(input logic [2:0] s);
    logic [`ANFA_NCS-1:0] v;
    v = '1;
    for (int i = 0; i < `ANFA_NCS; i++) begin
      if (s == 3'(i)) begin
        v[i] = 1'b0;
      end
    end
    return v;
  endfunction : cs_decode

  // a zero field runs as one cycle; a zero count would also expire after one cycle
  function automatic logic [`ANFA_CW-1:0] atleast1(
    input logic [`ANFA_CW-1:0] c);
    return (c == '0) ? `ANFA_CW'(1) : c;
  endfunction : atleast1

  function automatic logic is_mux(input anfa_op_t o);
    return (o == ANFA_OP_MREAD) || (o == ANFA_OP_MWRITE);
  endfunction : is_mux

  function automatic logic [1:0] n_words(input anfa_op_t o);
    case (o)
      ANFA_OP_READ32: n_words = 2'd1;
      ANFA_OP_PAGE4: n_words = 2'(`ANFA_PAGE_WORDS - 1);
      default: n_words = 2'd0;
    endcase
  endfunction : n_words

  // countdown still running: more than one cycle left
  function automatic logic counting(input logic [`ANFA_CW-1:0] c);
    return c > `ANFA_CW'(1);
  endfunction : counting

  // a second word lands in the upper half only for a 32-bit read
  function automatic logic [31:0] place_word(input anfa_op_t o,
    input logic [1:0] w, input logic [31:0] prev,
    input logic [`ANFA_DW-1:0] din);
    logic [31:0] v;
    v = {16'h0000, din};
    if (o == ANFA_OP_READ32 && w[0]) begin
      v = {din, prev[15:0]};
    end
    return v;
  endfunction : place_word

  logic waiting;
  // looked at only on the edge that would end a phase
  // RULE2: selected wait input stalls
  assign waiting = r_q.wait_en & wait_in[r_q.wait_sel];

  always_comb begin
    st_d = st_q;
    r_d = r_q;
    cnt_d = cnt_q;
    word_d = word_q;
    pins_d = pins;
    rd_valid_d = 1'b0;
    rd_last_d = 1'b0;
    done_d = 1'b0;
    rd_data_d = rd_data;
    req_ready_d = 1'b0;
    case (st_q)
      ANFA_IDLE: begin
        req_ready_d = 1'b1;
        // park every strobe while no access is framed
        pins_d.cs_n = '1;
        pins_d.adv_n = 1'b1;
        pins_d.oe_n = 1'b1;
        pins_d.we_n = 1'b1;
        pins_d.ad_oe = 1'b0;
        pins_d.low_byte_enable_n = 1'b1;
        pins_d.high_byte_enable_n = 1'b1;
        if (req_valid && req_ready) begin
          req_ready_d = 1'b0;
          r_d = req;
          word_d = 2'd0;
          rd_data_d = '0;
          // RULE1: frame with one chip select
          pins_d.cs_n = cs_decode(req.cs_sel);
          pins_d.addr = req.addr;
          pins_d.low_byte_enable_n = req.be_n[0];
          pins_d.high_byte_enable_n = req.be_n[1];
          if (is_mux(req.op)) begin
            // RULE12: low address on shared lines first
            pins_d.ad_out = req.addr[`ANFA_DW-1:0];
            pins_d.ad_oe = 1'b1;
            // RULE13: strobe only with address on bus
            pins_d.adv_n = 1'b0;
            cnt_d = atleast1(ADV_CYC);
            st_d = ANFA_ADDR;
          end else begin
            pins_d.adv_n = 1'b0;
            pins_d.oe_n = 1'b0;
            // RULE4: first capture timed by field
            // RULE5: page first word, same delay
            cnt_d = atleast1(req.first_sample_delay_field);
            st_d = ANFA_ACC;
          end
        end
      end

      ANFA_ADDR: begin
        if (counting(cnt_q)) begin
          cnt_d = cnt_q - `ANFA_CW'(1);
        end else begin
          // RULE13: strobe released on the edge the data phase starts
          pins_d.adv_n = 1'b1;
          if (r_q.op == ANFA_OP_MWRITE) begin
            // RULE12: replace address with write data
            pins_d.ad_out = r_q.wdata;
            pins_d.we_n = 1'b0;
            cnt_d = atleast1(WR_CYC);
            st_d = ANFA_WDATA;
          end else begin
            pins_d.ad_oe = 1'b0;
            pins_d.oe_n = 1'b0;
            cnt_d = atleast1(r_q.first_sample_delay_field);
            st_d = ANFA_ACC;
          end
        end
      end

      ANFA_ACC, ANFA_PAGE: begin
        if (st_q == ANFA_ACC) begin
          pins_d.adv_n = 1'b1;
        end
        if (counting(cnt_q)) begin
          cnt_d = cnt_q - `ANFA_CW'(1);
        end else if (!waiting) begin
          // RULE3: sample on the counted edge
          rd_valid_d = 1'b1;
          // RULE10: two words form a 32-bit result
          rd_data_d = place_word(r_q.op, word_q, rd_data, ad_in);
          if (word_q == n_words(r_q.op)) begin
            rd_last_d = 1'b1;
            pins_d.oe_n = 1'b1;
            pins_d.cs_n = '1;
            cnt_d = atleast1(IDLE_CYC);
            st_d = ANFA_DONE;
          end else begin
            word_d = word_q + 2'd1;
            // RULE9: next word address
            pins_d.addr = pins.addr + `ANFA_AW'(1);
            // RULE5: first word after delay field
            // RULE6: later words after interval
            // RULE7: address phase lasts the interval
            // RULE8: interval field kept separate
            cnt_d = atleast1(r_q.page_word_interval_field);
            st_d = ANFA_PAGE;
          end
        end
      end

      ANFA_WDATA: begin
        if (counting(cnt_q)) begin
          cnt_d = cnt_q - `ANFA_CW'(1);
        end else if (!waiting) begin
          pins_d.we_n = 1'b1;
          pins_d.cs_n = '1;
          cnt_d = atleast1(IDLE_CYC);
          st_d = ANFA_DONE;
        end
      end

      ANFA_DONE: begin
        pins_d.ad_oe = 1'b0;
        pins_d.low_byte_enable_n = 1'b1;
        pins_d.high_byte_enable_n = 1'b1;
        if (counting(cnt_q)) begin
          cnt_d = cnt_q - `ANFA_CW'(1);
        end else begin
          done_d = 1'b1;
          req_ready_d = 1'b1;
          st_d = ANFA_IDLE;
        end
      end

      default: begin
        st_d = ANFA_IDLE;
      end
    endcase
  end

  // RULE11: one internal clock, none exported
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ANFA_IDLE;
      r_q <= '0;
      cnt_q <= '0;
      word_q <= '0;
      pins <= '{
        cs_n: '1,
        addr: '0,
        low_byte_enable_n: 1'b1,
        high_byte_enable_n: 1'b1,
        adv_n: 1'b1,
        oe_n: 1'b1,
        we_n: 1'b1,
        ad_out: '0,
        ad_oe: 1'b0
      };
      rd_valid <= 1'b0;
      rd_last <= 1'b0;
      rd_data <= '0;
      done <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      st_q <= st_d;
      r_q <= r_d;
      cnt_q <= cnt_d;
      word_q <= word_d;
      pins <= pins_d;
      rd_valid <= rd_valid_d;
      rd_last <= rd_last_d;
      rd_data <= rd_data_d;
      done <= done_d;
      req_ready <= req_ready_d;
    end
  end
endmodule : anfa_seq
`default_nettype wire

// ---- common/anfa_cfg.svh ----
`ifndef ANFA_CFG_SVH
`define ANFA_CFG_SVH
// widths and default timing counts, in functional-clock cycles
`define ANFA_NCS 6
`define ANFA_NWAIT 2
`define ANFA_DW 16
`define ANFA_AW 27
`define ANFA_CW 5
`define ANFA_PAGE_WORDS 4
`define ANFA_ADV_CYC 5'h01
`define ANFA_WR_CYC 5'h04
`define ANFA_IDLE_CYC 5'h01
`endif

// ---- common/anfa_pkg.sv ----
`default_nettype none
`include "anfa_cfg.svh"
package anfa_pkg;
  typedef enum logic [2:0] {
    ANFA_OP_READ1 = 3'h0,
    ANFA_OP_READ32 = 3'h1,
    ANFA_OP_PAGE4 = 3'h2,
    ANFA_OP_MREAD = 3'h3,
    ANFA_OP_MWRITE = 3'h4
  } anfa_op_t;

  typedef struct packed {
    anfa_op_t op;
    logic [2:0] cs_sel;
    logic wait_sel;
    logic wait_en;
    logic [`ANFA_AW-1:0] addr;
    logic [1:0] be_n;
    logic [`ANFA_DW-1:0] wdata;
    logic [`ANFA_CW-1:0] first_sample_delay_field;
    logic [`ANFA_CW-1:0] page_word_interval_field;
  } anfa_req_t;

  typedef struct packed {
    logic [`ANFA_NCS-1:0] cs_n;
    logic [`ANFA_AW-1:0] addr;
    logic low_byte_enable_n;
    logic high_byte_enable_n;
    logic adv_n;
    logic oe_n;
    logic we_n;
    logic [`ANFA_DW-1:0] ad_out;
    logic ad_oe;
  } anfa_pins_t;

  // gray order in declaration order; steps along the state path flip up to three bits
  typedef enum logic [2:0] {
    ANFA_IDLE = 3'b000,
    ANFA_ADDR = 3'b001,
    ANFA_ACC = 3'b011,
    ANFA_PAGE = 3'b010,
    ANFA_WDATA = 3'b110,
    ANFA_DONE = 3'b111
  } anfa_state_t;
endpackage : anfa_pkg
`default_nettype wire

// ---- tb/anfa_flash_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module anfa_flash_model
  import anfa_pkg::*;
(
  input wire anfa_pins_t pins, // controller pins
  input wire logic stall, // hold wait line 1 high
  output logic [15:0] ad_in, // data lines to controller
  output logic [1:0] wait_in // wait lines
);
  logic [15:0] last = 16'h0000;
  assign wait_in = {stall, 1'b0};
  always @* begin
    if (!pins.oe_n && !pins.ad_oe && pins.cs_n != 6'h3f) begin
      ad_in = pins.addr[15:0] ^ 16'ha5a5;
      last = ad_in;
    end else begin
      ad_in = ~last;
    end
  end
endmodule : anfa_flash_model
`default_nettype wire

// ---- tb/anfa_seq_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "anfa_cfg.svh"
module anfa_seq_sva
  import anfa_pkg::*;
#(
  parameter logic [`ANFA_CW-1:0] ADV_CYC = `ANFA_ADV_CYC
) (
  input wire logic core_clk, // clock
  input wire logic rstn, // reset
  input wire logic req_valid, // request
  input wire anfa_req_t req, // request body
  input wire logic req_ready, // idle
  input wire logic [`ANFA_NWAIT-1:0] wait_in, // wait lines
  input wire anfa_pins_t pins, // pins
  input wire logic rd_valid, // word captured
  input wire logic [31:0] rd_data, // read data
  input wire logic rd_last // final word
);
  anfa_req_t lat_q;
  logic [7:0] cnt_q;
  logic [2:0] nw_q;
  wire logic take = req_valid && req_ready;
  wire logic mux = lat_q.op == ANFA_OP_MREAD;
  wire logic [7:0] fd = 8'(lat_q.first_sample_delay_field);
  wire logic [7:0] pd = 8'(lat_q.page_word_interval_field);
  wire logic [7:0] first = (fd == 8'h00 ? 8'h01 : fd) + 8'h01
    + (mux ? 8'(ADV_CYC) : 8'h00);
  wire logic [7:0] nxt = pd == 8'h00 ? 8'h01 : pd;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lat_q <= '0;
      cnt_q <= 8'h00;
      nw_q <= 3'h0;
    end else begin
      if (take) lat_q <= req;
      cnt_q <= (take || rd_valid) ? 8'h01 : cnt_q + 8'h01;
      nw_q <= take ? 3'h0 : nw_q + 3'(rd_valid);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_cs_single: assert property ($onehot0(~pins.cs_n))
    else $error("more than one chip select low");
  a_cs_select: assert property (take |=>
    pins.cs_n == ~(6'h01 << $past(req.cs_sel)))
    else $error("wrong chip select");
  a_first_sample: assert property (rd_valid && nw_q == 3'h0
    && !lat_q.wait_en |-> cnt_q == first) else $error("first word late");
  a_next_sample: assert property (rd_valid && nw_q != 3'h0
    && !lat_q.wait_en |-> cnt_q == nxt) else $error("next word timing");
  a_word_count: assert property (rd_last |-> rd_valid && nw_q ==
    (lat_q.op == ANFA_OP_PAGE4 ? 3'h3 : lat_q.op == ANFA_OP_READ32))
    else $error("word count");
  a_upper_zero: assert property (rd_valid && lat_q.op != ANFA_OP_READ32
    |-> rd_data[31:16] == 16'h0000) else $error("upper half set");
  a_wait_hold: assert property (rd_valid && lat_q.wait_en
    |-> !$past(wait_in[lat_q.wait_sel])) else $error("sampled in wait");
  a_addr_phase: assert property (!pins.adv_n && pins.ad_oe
    |-> pins.ad_out == pins.addr[15:0]) else $error("address phase");
  a_write_data: assert property (!pins.we_n |-> pins.adv_n
    && pins.ad_oe && pins.ad_out == lat_q.wdata) else $error("write data");
  a_byte_enable: assert property (take |=>
    {pins.high_byte_enable_n, pins.low_byte_enable_n} == $past(req.be_n))
    else $error("byte enables");
  a_oe_sample: assert property (rd_valid |->
    !$past(pins.oe_n) && $past(pins.cs_n) != 6'h3f)
    else $error("sampled outside read strobe");
  a_page_addr: assert property (rd_valid && !rd_last |->
    pins.addr == $past(pins.addr) + 27'h000_0001)
    else $error("next word address");
  c_page: cover property (rd_last && lat_q.op == ANFA_OP_PAGE4);
  c_write: cover property (!pins.we_n);
  c_wait: cover property (rd_valid && lat_q.wait_en && lat_q.wait_sel);
endmodule : anfa_seq_sva
bind anfa_seq anfa_seq_sva #(.ADV_CYC(ADV_CYC)) sva_u (.core_clk(core_clk),
  .rstn(rstn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .wait_in(wait_in), .pins(pins), .rd_valid(rd_valid), .rd_data(rd_data),
  .rd_last(rd_last));
`default_nettype wire

// ---- tb/anfa_seq_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module anfa_seq_tb_top;
  import anfa_pkg::*;
  typedef struct {anfa_op_t op; int cs; logic [26:0] a; int f; int p;
    int lat; int nw; logic [31:0] d;} anfa_row_t;
  anfa_row_t rows [6] = '{
    '{ANFA_OP_READ1, 0, 27'h000_0010, 2, 1, 3, 1, 32'h0000_a5b5},
    '{ANFA_OP_READ32, 1, 27'h000_0020, 3, 1, 4, 2, 32'ha584_a585},
    '{ANFA_OP_PAGE4, 2, 27'h000_0040, 4, 2, 5, 4, 32'h0000_a5e6},
    '{ANFA_OP_MREAD, 3, 27'h000_1234, 2, 1, 4, 1, 32'h0000_b791},
    '{ANFA_OP_MWRITE, 4, 27'h000_0050, 2, 1, 0, 0, 32'h0000_0000},
    '{ANFA_OP_READ1, 5, 27'h000_0077, 0, 1, 2, 1, 32'h0000_a5d2}};
  logic core_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, stall = 1'b0;
  anfa_req_t req = '0, r;
  logic req_ready, rd_valid, rd_last, done;
  logic [1:0] wait_in;
  logic [15:0] ad_in;
  logic [31:0] rd_data, dat;
  logic [5:0] csn;
  anfa_pins_t pins;
  int failures = 0, comparisons = 0, cyc = 0, lat, nw;
  anfa_seq dut_u (.core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .wait_in(wait_in), .ad_in(ad_in),
    .pins(pins), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_last(rd_last), .done(done));
  anfa_flash_model flash_u (.pins(pins), .stall(stall), .ad_in(ad_in),
    .wait_in(wait_in));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic complete_run;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 2000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (e !== g) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic run(input anfa_req_t q);
    int n;
    n = 0;
    lat = 0;
    nw = 0;
    csn = 6'h3f;
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge core_clk);
      #2 n++;
    end
    req = q;
    req_valid = 1'b1;
    @(posedge core_clk);
    #2 req_valid = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 100) begin
      if (pins.cs_n !== 6'h3f) csn = pins.cs_n;
      if (rd_valid === 1'b1 && nw++ == 0) lat = n;
      @(posedge core_clk);
      #2 n++;
    end
    dat = rd_data;
  endtask : run
  initial begin
    repeat (3) @(posedge core_clk);
    #2 chk("reset_cs", 32'h0000_003f, 32'(pins.cs_n));
    chk("reset_ready", 32'h0000_0000, 32'(req_ready));
    rstn = 1'b1;
    foreach (rows[i]) begin
      r = '0;
      r.op = rows[i].op;
      r.cs_sel = 3'(rows[i].cs);
      r.addr = rows[i].a;
      r.be_n = 2'(i);
      r.wdata = 16'hbeef;
      r.first_sample_delay_field = 5'(rows[i].f);
      r.page_word_interval_field = 5'(rows[i].p);
      run(r);
      chk("latency", 32'(rows[i].lat), 32'(lat));
      chk("words", 32'(rows[i].nw), 32'(nw));
      chk("data", rows[i].d, dat);
      chk("cs", 32'(6'h3f ^ (6'h01 << rows[i].cs)), 32'(csn));
    end
    r = '0;
    r.addr = 27'h000_0010;
    r.first_sample_delay_field = 5'h02;
    r.wait_en = 1'b1;
    stall = 1'b1;
    run(r);
    chk("unsel_wait", 32'h0000_0003, 32'(lat));
    r.wait_sel = 1'b1;
    fork
      run(r);
      begin
        repeat (6) @(posedge core_clk);
        #2 stall = 1'b0;
      end
    join
    chk("sel_wait", 32'h0000_0001, 32'(lat > 3));
    chk("wait_data", 32'h0000_a5b5, dat);
    r.wait_en = 1'b0;
    r.op = ANFA_OP_PAGE4;
    fork
      run(r);
      begin
        repeat (3) @(posedge core_clk);
        #2 rstn = 1'b0;
        #1 chk("midrst_cs", 32'h0000_003f, 32'(pins.cs_n));
        chk("midrst_ready", 32'h0000_0000, 32'(req_ready));
        @(posedge core_clk);
        #2 rstn = 1'b1;
      end
    join
    r.op = ANFA_OP_READ1;
    run(r);
    chk("after_rst_lat", 32'h0000_0003, 32'(lat));
    chk("after_rst_data", 32'h0000_a5b5, dat);
    complete_run();
  end
endmodule : anfa_seq_tb_top
`default_nettype wire
